// ### hdl/pmta_pkg.sv
package pmta_pkg;
   // program address layout
   localparam int PMTA_EA_W = 16;           // effective address width
   localparam int PMTA_PAGE_W = 8;          // page select width
   localparam int PMTA_ADDR_W = 24;         // full program address width
   localparam int PMTA_WORD_W = 24;         // program word width
   localparam int PMTA_LOW_MSB = 15;        // low lane top bit
   localparam int PMTA_HIGH_LSB = 16;       // high lane bottom bit
   localparam int PMTA_HIGH_MSB = 23;       // high lane top bit
   localparam int PMTA_BYTE_W = 8;          // byte width
   localparam int PMTA_ERASE_WORDS = 1024;  // instructions per erase page
   localparam logic [7:0] PMTA_PHANTOM = 8'h00; // high byte of high lane

   // operation codes from the core
   typedef enum logic [2:0] {
      PMTA_OP_NONE,
      PMTA_OP_RD_LOW,
      PMTA_OP_WR_LOW,
      PMTA_OP_RD_HIGH,
      PMTA_OP_WR_HIGH,
      PMTA_OP_ERASE
   } pmta_op_t;
endpackage : pmta_pkg

// ### hdl/pmta_lane.sv
`timescale 1ns/1ps
// merges write data into one 16-bit lane, byte or word
module pmta_lane
   import pmta_pkg::*;
(
   input wire logic [15:0] old_lane,  // current lane contents
   input wire logic [15:0] wr_data,   // data from the core
   input wire logic byte_mode,        // byte access
   input wire logic byte_sel,         // effective address bit 0
   output logic [15:0] new_lane       // merged lane
);
   // the untouched byte keeps its old value
   always_comb begin
      new_lane = wr_data;
      if (byte_mode) begin
         if (byte_sel) begin
            new_lane = {wr_data[PMTA_BYTE_W-1:0], old_lane[PMTA_BYTE_W-1:0]};
         end else begin
            new_lane = {old_lane[15:PMTA_BYTE_W], wr_data[PMTA_BYTE_W-1:0]};
         end
      end
   end
endmodule : pmta_lane

// ### hdl/pmta_top.sv
`timescale 1ns/1ps
module pmta_top
   import pmta_pkg::*;
#(
   parameter int DEPTH = 2048 // program words modelled in the array
)
(
   input wire logic clk_sys,                 // system clock
   input wire logic sys_rst,                 // sync reset, high
   input wire pmta_op_t op,                  // operation from core
   input wire logic [7:0] program_page_select, // page select value
   input wire logic [15:0] effective_address, // from working register
   input wire logic byte_mode,               // byte access
   input wire logic [15:0] wr_data,          // write data
   output logic [15:0] rd_data_q,            // read result
   output logic rd_valid_q,                  // read result strobe
   output logic wr_done_q,                   // write or erase done
   output logic [23:0] prog_addr_q           // last target address
);
   localparam int AW = $clog2(DEPTH);
   localparam int PG_W = $clog2(PMTA_ERASE_WORDS);

   initial begin
      // the word index is a plain bit slice, so depth must be a power of two
      if (DEPTH < PMTA_ERASE_WORDS || DEPTH % PMTA_ERASE_WORDS != 0 ||
          (DEPTH & (DEPTH - 1)) != 0)
         $error("depth must be whole erase pages");
   end

   // full target address, one place only
   function automatic logic [23:0] make_addr(input logic [7:0] pg,
                                             input logic [15:0] ea);
      make_addr = {pg, ea};
   endfunction : make_addr

   // word index: program words sit at even addresses
   function automatic logic [AW-1:0] word_idx(input logic [23:0] a);
      word_idx = a[AW:1];
   endfunction : word_idx

   // the flash array; the only write path is this block
   logic [PMTA_WORD_W-1:0] mem [DEPTH];

   logic [23:0] addr;           // current target
   logic [AW-1:0] idx;          // word index
   logic [23:0] cur;            // addressed word
   logic [15:0] low_new;        // merged low lane
   logic [15:0] high_new;       // merged high lane
   logic [15:0] high_old;       // high lane with phantom byte
   logic [15:0] rd_data_d;      // next read result
   logic rd_valid_d;            // next read strobe
   logic wr_done_d;             // next write strobe
   logic [23:0] prog_addr_d;    // next target address

   assign addr = make_addr(program_page_select, effective_address);
   assign idx = word_idx(addr);
   assign cur = mem[idx];
   assign high_old = {PMTA_PHANTOM, cur[PMTA_HIGH_MSB:PMTA_HIGH_LSB]};

   // byte merge for each lane
   pmta_lane u_low (
      .old_lane(cur[PMTA_LOW_MSB:0]),
      .wr_data(wr_data),
      .byte_mode(byte_mode),
      .byte_sel(effective_address[0]),
      .new_lane(low_new)
   );
   pmta_lane u_high (
      .old_lane(high_old),
      .wr_data(wr_data),
      .byte_mode(byte_mode),
      .byte_sel(effective_address[0]),
      .new_lane(high_new)
   );

   // read path and handshake next values
   always_comb begin
      rd_data_d = rd_data_q;
      rd_valid_d = 1'b0;
      wr_done_d = 1'b0;
      prog_addr_d = prog_addr_q;
      case (op)
         PMTA_OP_RD_LOW: begin
            rd_valid_d = 1'b1;
            prog_addr_d = addr;
            if (byte_mode) begin
               rd_data_d = effective_address[0] ?
                  {8'h00, cur[PMTA_LOW_MSB:PMTA_BYTE_W]} :
                  {8'h00, cur[PMTA_BYTE_W-1:0]};
            end else begin
               rd_data_d = cur[PMTA_LOW_MSB:0];
            end
         end
         PMTA_OP_RD_HIGH: begin
            rd_valid_d = 1'b1;
            prog_addr_d = addr;
            if (byte_mode) begin
               rd_data_d = effective_address[0] ? {8'h00, PMTA_PHANTOM} :
                  {8'h00, cur[PMTA_HIGH_MSB:PMTA_HIGH_LSB]};
            end else begin
               rd_data_d = high_old;
            end
         end
         PMTA_OP_WR_LOW, PMTA_OP_WR_HIGH, PMTA_OP_ERASE: begin
            wr_done_d = 1'b1;
            prog_addr_d = addr;
         end
         default: begin
            rd_valid_d = 1'b0;
         end
      endcase
   end

   // output registers
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rd_data_q <= 16'h0000;
         rd_valid_q <= 1'b0;
         wr_done_q <= 1'b0;
         prog_addr_q <= 24'h00_0000;
      end else begin
         rd_data_q <= rd_data_d;
         rd_valid_q <= rd_valid_d;
         wr_done_q <= wr_done_d;
         prog_addr_q <= prog_addr_d;
      end
   end

   // array update: one word per write, whole page per erase
   // no reset: flash keeps contents, sys_rst only blocks array writes
   always_ff @(posedge clk_sys) begin
      if (!sys_rst) begin
         case (op)
            PMTA_OP_WR_LOW: begin
               mem[idx] <= {cur[PMTA_HIGH_MSB:PMTA_HIGH_LSB], low_new};
            end
            PMTA_OP_WR_HIGH: begin
               mem[idx] <= {high_new[PMTA_BYTE_W-1:0],
                            cur[PMTA_LOW_MSB:0]};
            end
            PMTA_OP_ERASE: begin
               for (int i = 0; i < PMTA_ERASE_WORDS; i++) begin
                  mem[{idx[AW-1:PG_W], PG_W'(i)}] <= '1;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // assertions
   // a read of either lane, taken on this edge
   sequence read_taken_s;
      op == PMTA_OP_RD_LOW || op == PMTA_OP_RD_HIGH;
   endsequence : read_taken_s
   // a request that may change the array
   sequence change_taken_s;
      op == PMTA_OP_WR_LOW || op == PMTA_OP_WR_HIGH || op == PMTA_OP_ERASE;
   endsequence : change_taken_s
   rd_pulse_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      read_taken_s |=> rd_valid_q)
      else $error("read not answered");
   idle_quiet_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      op == PMTA_OP_NONE |=> !rd_valid_q && !wr_done_q)
      else $error("strobe without a request");
   // the read result must stand until the next read replaces it
   rd_hold_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      op != PMTA_OP_RD_LOW && op != PMTA_OP_RD_HIGH |=> $stable(rd_data_q))
      else $error("read result moved without a read");
   addr_form_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (op != PMTA_OP_NONE) |=> prog_addr_q ==
         {$past(program_page_select), $past(effective_address)})
      else $error("address formed wrong");
   low_word_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (op == PMTA_OP_RD_LOW && !byte_mode) |=>
         rd_data_q == $past(cur[15:0]))
      else $error("low word read wrong");
   low_lands_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      op == PMTA_OP_WR_LOW && !byte_mode |=>
         mem[$past(idx)][PMTA_LOW_MSB:0] == $past(wr_data))
      else $error("low word write lost");
   low_byte_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (op == PMTA_OP_RD_LOW && byte_mode) |=> rd_data_q[15:8] == 8'h00)
      else $error("byte read upper not zero");
   high_word_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (op == PMTA_OP_RD_HIGH && !byte_mode) |=>
         rd_data_q[7:0] == $past(cur[23:16]))
      else $error("high read wrong");
   high_lands_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      op == PMTA_OP_WR_HIGH && (!byte_mode || !effective_address[0]) |=>
         mem[$past(idx)][PMTA_HIGH_MSB:PMTA_HIGH_LSB] == $past(wr_data[7:0]))
      else $error("high write lost");
   high_keep_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      op == PMTA_OP_WR_HIGH |=>
         mem[$past(idx)][PMTA_LOW_MSB:0] == $past(cur[PMTA_LOW_MSB:0]))
      else $error("high write disturbed low lane");
   high_byte_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (op == PMTA_OP_RD_HIGH && byte_mode && effective_address[0]) |=>
         rd_data_q == 16'h0000)
      else $error("phantom byte not zero");
   phantom_write_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      op == PMTA_OP_WR_HIGH && byte_mode && effective_address[0] |=>
         mem[$past(idx)] == $past(cur))
      else $error("phantom byte write changed the word");
   wr_keep_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (op == PMTA_OP_WR_LOW && byte_mode && !effective_address[0]) |=>
         mem[$past(idx)][15:8] == $past(cur[15:8]))
      else $error("byte write disturbed other byte");
   low_keep_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      op == PMTA_OP_WR_LOW && byte_mode && effective_address[0] |=>
         mem[$past(idx)][PMTA_BYTE_W-1:0] == $past(cur[PMTA_BYTE_W-1:0]))
      else $error("upper byte write disturbed lower byte");
   wr_done_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      change_taken_s |=> wr_done_q && !rd_valid_q)
      else $error("write not acknowledged");
   erase_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (op == PMTA_OP_ERASE) |=> mem[$past(idx)] == 24'hFF_FFFF)
      else $error("erase left data");
endmodule : pmta_top

// ### verif/pmta_core_model.sv
`timescale 1ns/1ps
// core side: one table op per call, driven 1 ns after the edge
module pmta_core_model
   import pmta_pkg::*;
(
   input wire logic clk_sys, // system clock
   output pmta_op_t op, // operation
   output logic [7:0] program_page_select, // page byte
   output logic [15:0] effective_address, // low address
   output logic byte_mode, // byte access
   output logic [15:0] wr_data // write data
);
   // idle lines at time zero
   initial begin
      op = PMTA_OP_NONE;
      program_page_select = 8'h00;
      effective_address = 16'h0000;
      byte_mode = 1'b0;
      wr_data = 16'h0000;
   end
   // hold the request one cycle, then idle; write and erase requests come only from here
   task automatic issue(input pmta_op_t o, input logic [7:0] pg,
      input logic [15:0] ea, input logic bm, input logic [15:0] wd);
      @(posedge clk_sys);
      #1;
      op = o;
      program_page_select = pg;
      effective_address = ea;
      byte_mode = bm;
      wr_data = wd;
      @(posedge clk_sys);
      #1;
      op = PMTA_OP_NONE;
      // stale data is inverted so it never passes for a fresh value
      wr_data = ~wd;
   endtask : issue
endmodule : pmta_core_model

// ### verif/pmta_top_bench.sv
`timescale 1ns/1ps
// table reads, writes and erase through the core model
module pmta_top_bench
   import pmta_pkg::*;
;
   logic clk_sys = 1'b0; // 125 MHz clock
   logic sys_rst = 1'b1; // reset, high
   pmta_op_t op; // operation
   logic [7:0] pg; // page byte
   logic [15:0] ea; // effective address
   logic bm; // byte access
   logic [15:0] wd; // write data
   logic [15:0] rd_data_q; // read result
   logic rd_valid_q; // read strobe
   logic wr_done_q; // write strobe
   logic [23:0] prog_addr_q; // target address
   int bad_count = 0; // mismatches
   int comparisons = 0; // checks made
   always #4 clk_sys = ~clk_sys;
   pmta_core_model core(.clk_sys(clk_sys), .op(op),
      .program_page_select(pg), .effective_address(ea),
      .byte_mode(bm), .wr_data(wd));
   pmta_top uut(.clk_sys(clk_sys), .sys_rst(sys_rst), .op(op),
      .program_page_select(pg), .effective_address(ea),
      .byte_mode(bm), .wr_data(wd), .rd_data_q(rd_data_q),
      .rd_valid_q(rd_valid_q), .wr_done_q(wr_done_q),
      .prog_addr_q(prog_addr_q));
   // case equality so an unknown never matches
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // read and check strobe and data one cycle later
   task automatic rd(input pmta_op_t o, input logic [15:0] a,
      input logic b, input logic [15:0] exp);
      core.issue(o, 8'h00, a, b, 16'h0000);
      chk({23'h0, rd_valid_q}, 24'h1);
      chk({8'h00, rd_data_q}, {8'h00, exp});
   endtask : rd
   // write or erase and check the done strobe
   task automatic wr(input pmta_op_t o, input logic [15:0] a,
      input logic b, input logic [15:0] d);
      core.issue(o, 8'h00, a, b, d);
      chk({23'h0, wr_done_q}, 24'h1);
   endtask : wr
   // write first so the read never meets an unwritten word
   task automatic t_addr();
      core.issue(PMTA_OP_WR_LOW, 8'h5a, 16'h3c96, 1'b0, 16'h2468);
      chk(prog_addr_q, 24'h5a_3c96);
      core.issue(PMTA_OP_RD_LOW, 8'ha5, 16'h3c96, 1'b0, 16'h0000);
      chk(prog_addr_q, 24'ha5_3c96);
      chk({8'h00, rd_data_q}, 24'h00_2468);
      @(posedge clk_sys);
      #1;
      chk({23'h0, rd_valid_q}, 24'h0);
   endtask : t_addr
   task automatic t_low();
      wr(PMTA_OP_WR_LOW, 16'h0010, 1'b0, 16'h1234);
      rd(PMTA_OP_RD_LOW, 16'h0010, 1'b0, 16'h1234);
      wr(PMTA_OP_WR_LOW, 16'h0011, 1'b1, 16'h00ab);
      rd(PMTA_OP_RD_LOW, 16'h0010, 1'b1, 16'h0034);
      rd(PMTA_OP_RD_LOW, 16'h0011, 1'b1, 16'h00ab);
      rd(PMTA_OP_RD_LOW, 16'h0010, 1'b0, 16'hab34);
      wr(PMTA_OP_WR_LOW, 16'h0010, 1'b1, 16'h0056);
      rd(PMTA_OP_RD_LOW, 16'h0010, 1'b0, 16'hab56);
   endtask : t_low
   task automatic t_high();
      wr(PMTA_OP_WR_HIGH, 16'h0010, 1'b0, 16'h77c5);
      rd(PMTA_OP_RD_HIGH, 16'h0010, 1'b0, 16'h00c5);
      rd(PMTA_OP_RD_LOW, 16'h0010, 1'b0, 16'hab56);
      wr(PMTA_OP_WR_HIGH, 16'h0011, 1'b1, 16'h0099);
      rd(PMTA_OP_RD_HIGH, 16'h0010, 1'b1, 16'h00c5);
      rd(PMTA_OP_RD_HIGH, 16'h0011, 1'b1, 16'h0000);
   endtask : t_high
   // a request during reset is ignored and the outputs stay clear
   task automatic t_reset();
      @(posedge clk_sys);
      #1;
      sys_rst = 1'b1;
      core.issue(PMTA_OP_WR_LOW, 8'h00, 16'h0010, 1'b0, 16'hdead);
      chk({23'h0, wr_done_q}, 24'h0);
      chk(prog_addr_q, 24'h0);
      chk({8'h00, rd_data_q}, 24'h0);
      @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
      rd(PMTA_OP_RD_LOW, 16'h0010, 1'b0, 16'hab56);
   endtask : t_reset
   // erase hits only the 1024-word page holding the address
   task automatic t_erase();
      wr(PMTA_OP_WR_LOW, 16'h0004, 1'b0, 16'h5a5a);
      wr(PMTA_OP_WR_LOW, 16'h0804, 1'b0, 16'h0f0f);
      wr(PMTA_OP_ERASE, 16'h0ffe, 1'b0, 16'h0000);
      rd(PMTA_OP_RD_LOW, 16'h0804, 1'b0, 16'hffff);
      rd(PMTA_OP_RD_HIGH, 16'h0804, 1'b0, 16'h00ff);
      rd(PMTA_OP_RD_LOW, 16'h0004, 1'b0, 16'h5a5a);
   endtask : t_erase
   task automatic conclude();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude
   // main sequence: two reset cycles, then the scenarios
   initial begin
      repeat (2) @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
      chk({rd_data_q, rd_valid_q, wr_done_q, 6'h00}, 24'h0);
      chk(prog_addr_q, 24'h0);
      t_addr();
      t_low();
      t_high();
      t_reset();
      t_erase();
      conclude();
   end
   // a hang counts as a mismatch
   initial begin
      repeat (5000) @(posedge clk_sys);
      bad_count++;
      conclude();
   end
endmodule : pmta_top_bench
